/* File: clock_mod_pkg.sv */
// constants for the on-demand clock modulation block
// assumes a single core clock; shared by the design and its tests
package clock_mod_pkg;
  localparam int unsigned CTL_EN_BIT      = 4;      // modulation enable flag
  localparam int unsigned CTL_DUTY_LSB    = 1;      // duty field bits 3:1
  localparam int unsigned CTL_DUTY_W      = 3;
  localparam logic [2:0]  CTL_RESET_DUTY  = 3'h1;   // 12.5 percent default
  localparam logic        CTL_RESET_EN    = 1'h0;
  localparam logic [2:0]  DUTY_RESERVED   = 3'h0;
  localparam int unsigned MISC_TMON_BIT   = 3;      // thermal monitor enable
  localparam int unsigned FEAT_ACPI_BIT   = 22;     // thermal regs present
  localparam int unsigned FEAT_TMON_BIT   = 29;     // thermal monitor present
  localparam int unsigned SLOTS_PER_FRAME = 8;      // 12.5 percent steps
  localparam int unsigned CLK_PERIOD_NS   = 25;     // 40 MHz core clock
  localparam int unsigned SLOT_TIME_NS    = 100;    // length of one slot
  localparam int unsigned SLOT_CYCLES     =
    (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* File: on_demand_clock_modulation.sv */
// on-demand clock modulation: per-thread control copies, thermal override,
// internal stop-clock drive and interrupt hold-off while the core is stopped
// assumes: thermal_hot comes from the sensor domain, all else is on clk
`timescale 1ns/10ps
`default_nettype none
module on_demand_clock_modulation #(
  parameter int unsigned LP_COUNT    = 2,
  parameter int unsigned LP_W        = 1,
  parameter logic [2:0]  TMON_DUTY    = 3'h4,
  parameter logic        ACPI_PRESENT = 1'h1,
  parameter logic        TMON_PRESENT = 1'h1
) (
  input  wire logic            clk,
  input  wire logic            rst_b,
  input  wire logic            ctl_wr,
  input  wire logic [LP_W-1:0] ctl_wr_lp,
  input  wire logic [63:0]     ctl_wr_data,
  input  wire logic            ctl_rd,
  input  wire logic [LP_W-1:0] ctl_rd_lp,
  output logic      [63:0]     ctl_rd_data,
  input  wire logic [LP_W-1:0] active_lp,
  input  wire logic            misc_wr,
  input  wire logic [63:0]     misc_wr_data,
  input  wire logic            thermal_hot,
  output logic                 thermal_status,
  output logic      [31:0]     feature_flags,
  output logic                 core_stop_clk,
  input  wire logic            irq_req,
  output logic                 irq_deliver
);

  // one slot of the frame stops the core when its index is below the code
  function automatic logic slot_stops(input logic [2:0] idx,
                                      input logic [2:0] code);
    slot_stops = (idx < code);
  endfunction

  logic [2:0]  duty_q  [LP_COUNT];
  logic        en_q    [LP_COUNT];
  logic        tmon_en_q;
  logic        hot_meta_q;
  logic        hot_q;
  logic [7:0]  slot_cnt_q;
  logic [2:0]  slot_idx_q;
  logic        stop_q;
  logic        irq_pend_q;
  logic [63:0] rd_data_q;
  logic [2:0]  duty_sel;
  logic        tmon_hot;

  // separate copy per logical processor; software keeps them identical
  always_ff @(posedge clk) begin
    for (int i = 0; i < LP_COUNT; i++) begin
      if (!rst_b) begin
        en_q[i]   <= clock_mod_pkg::CTL_RESET_EN;
        duty_q[i] <= clock_mod_pkg::CTL_RESET_DUTY;
      end else if (ctl_wr && (ctl_wr_lp == LP_W'(i))) begin
        en_q[i]   <= ctl_wr_data[clock_mod_pkg::CTL_EN_BIT];
        duty_q[i] <= ctl_wr_data[clock_mod_pkg::CTL_DUTY_LSB +:
                                 clock_mod_pkg::CTL_DUTY_W];
      end
    end
  end

  // read back: reserved bits read as zero, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_data_q <= 64'h0;
    end else if (ctl_rd) begin
      rd_data_q <= '0;
      rd_data_q[clock_mod_pkg::CTL_EN_BIT] <= en_q[ctl_rd_lp];
      rd_data_q[clock_mod_pkg::CTL_DUTY_LSB +: clock_mod_pkg::CTL_DUTY_W]
        <= duty_q[ctl_rd_lp];
    end
  end
  assign ctl_rd_data = rd_data_q;

  // thermal monitor enable, off after reset until firmware sets it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tmon_en_q <= 1'h0;
    end else if (misc_wr) begin
      tmon_en_q <= misc_wr_data[clock_mod_pkg::MISC_TMON_BIT];
    end
  end

  // sensor crosses from its own domain; only hot_q is read by logic
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hot_meta_q <= 1'h0;
      hot_q      <= 1'h0;
    end else begin
      hot_meta_q <= thermal_hot;
      hot_q      <= hot_meta_q;
    end
  end
  assign thermal_status = hot_q;

  // capability bits are constants of this build
  always_comb begin
    feature_flags = 32'h0;
    feature_flags[clock_mod_pkg::FEAT_ACPI_BIT] = ACPI_PRESENT;
    feature_flags[clock_mod_pkg::FEAT_TMON_BIT] = TMON_PRESENT;
  end

  // duty choice: hot monitor wins, disabled or reserved code gives zero
  always_comb begin
    tmon_hot = tmon_en_q && hot_q;
    if (tmon_hot) begin
      duty_sel = TMON_DUTY;
    end else if (en_q[active_lp]) begin
      duty_sel = duty_q[active_lp];
    end else begin
      duty_sel = clock_mod_pkg::DUTY_RESERVED;
    end
  end

  // frame timing: eight slots of equal length, free running
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      slot_cnt_q <= 8'h0;
      slot_idx_q <= 3'h0;
    end else if (slot_cnt_q == 8'(clock_mod_pkg::SLOT_CYCLES - 1)) begin
      slot_cnt_q <= 8'h0;
      slot_idx_q <= slot_idx_q + 3'h1;
    end else begin
      slot_cnt_q <= slot_cnt_q + 8'h1;
    end
  end

  // internal stop-clock drive; the external pin is not an input here
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stop_q <= 1'h0;
    end else begin
      stop_q <= slot_stops(slot_idx_q, duty_sel);
    end
  end
  assign core_stop_clk = stop_q;

  // interrupts wait while stopped; a new request beats the clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_pend_q <= 1'h0;
    end else if (irq_req) begin
      irq_pend_q <= 1'h1;
    end else if (!stop_q) begin
      irq_pend_q <= 1'h0;
    end
  end
  assign irq_deliver = irq_pend_q && !stop_q;

  // all checks run on the core clock and, except tmon_reset_a, pause while reset is held
  default clocking chk_cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence idle_cause_s;
    !en_q[active_lp] && !tmon_hot;
  endsequence

  sequence hot_cause_s;
    tmon_hot && (slot_idx_q >= TMON_DUTY);
  endsequence

  // the hot monitor must also stop the clock in its own low slots
  sequence hot_stop_s;
    tmon_hot && (slot_idx_q < TMON_DUTY);
  endsequence

  off_no_stop_a: assert property (idle_cause_s |=> !stop_q)
    else $error("stop while modulation off");

  reserved_off_a: assert property (
    (en_q[active_lp] && duty_q[active_lp] == 3'h0 && !tmon_hot) |=> !stop_q)
    else $error("reserved code stopped clock");

  duty_slot_a: assert property (
    (en_q[active_lp] && !tmon_hot && slot_idx_q < duty_q[active_lp])
    |=> stop_q) else $error("programmed slot not stopped");

  duty_run_a: assert property (
    (en_q[active_lp] && !tmon_hot && slot_idx_q >= duty_q[active_lp])
    |=> !stop_q) else $error("run slot stopped");

  tmon_override_a: assert property (hot_cause_s |=> !stop_q)
    else $error("monitor duty not used");

  hot_stop_a: assert property (hot_stop_s |=> stop_q)
    else $error("monitor slot not stopped");

  // reset itself is the antecedent here, so this one is never disabled
  tmon_reset_a: assert property (disable iff (1'h0)
    !rst_b |=> !tmon_en_q) else $error("monitor enable survived reset");

  hot_flag_a: assert property (
    thermal_hot [*3] |-> ##0 thermal_status)
    else $error("hot flag lags sensor");

  irq_hold_a: assert property ((irq_req && stop_q) |=> irq_pend_q)
    else $error("interrupt lost");

  irq_block_a: assert property (stop_q |-> !irq_deliver)
    else $error("interrupt during stop");

  irq_keep_a: assert property (
    (irq_pend_q && stop_q) |=> irq_pend_q)
    else $error("pending interrupt dropped");

  feature_bits_a: assert property (
    feature_flags[clock_mod_pkg::FEAT_ACPI_BIT] == ACPI_PRESENT &&
    feature_flags[clock_mod_pkg::FEAT_TMON_BIT] == TMON_PRESENT)
    else $error("capability flags wrong");

  frame_step_a: assert property (
    (slot_cnt_q == 8'h0) |-> ##4 (slot_idx_q == $past(slot_idx_q, 4) + 3'h1))
    else $error("slot length wrong");

endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the on-demand clock modulation block
// assumes default parameters: two control copies, thermal duty of four
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        clk = 1'h0;
  logic        rst_b = 1'h0;
  logic        ctl_wr = 1'h0;
  logic [0:0]  ctl_wr_lp = 1'h0;
  logic [63:0] ctl_wr_data = 64'h0;
  logic        ctl_rd = 1'h0;
  logic [0:0]  ctl_rd_lp = 1'h0;
  logic [63:0] ctl_rd_data;
  logic [0:0]  active_lp = 1'h0;
  logic        misc_wr = 1'h0;
  logic [63:0] misc_wr_data = 64'h0;
  logic        thermal_hot = 1'h0;
  logic        thermal_status;
  logic [31:0] feature_flags;
  logic        core_stop_clk;
  logic        irq_req = 1'h0;
  logic        irq_deliver;
  int          fail_count = 0;
  int          checks = 0;
  int          cyc = 0;
  int          seen;
  int          bad;
  on_demand_clock_modulation u_on_demand_clock_modulation (
    .clk(clk), .rst_b(rst_b), .ctl_wr(ctl_wr), .ctl_wr_lp(ctl_wr_lp),
    .ctl_wr_data(ctl_wr_data), .ctl_rd(ctl_rd), .ctl_rd_lp(ctl_rd_lp),
    .ctl_rd_data(ctl_rd_data), .active_lp(active_lp), .misc_wr(misc_wr),
    .misc_wr_data(misc_wr_data), .thermal_hot(thermal_hot),
    .thermal_status(thermal_status), .feature_flags(feature_flags),
    .core_stop_clk(core_stop_clk), .irq_req(irq_req),
    .irq_deliver(irq_deliver));
  // 40 MHz core clock
  always #12.5 clk = ~clk;
  // the whole run needs about 1100 cycles, so this ceiling means a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // write strobes are one-cycle pulses launched on a rising edge
  task automatic wr(input logic [0:0] lp, input logic [63:0] d);
    @(posedge clk);
    ctl_wr <= 1'h1;
    ctl_wr_lp <= lp;
    ctl_wr_data <= d;
    @(posedge clk);
    ctl_wr <= 1'h0;
  endtask
  task automatic misc(input logic [63:0] d);
    @(posedge clk);
    misc_wr <= 1'h1;
    misc_wr_data <= d;
    @(posedge clk);
    misc_wr <= 1'h0;
  endtask
  // read data is registered, so look one edge after the strobe
  task automatic rd(input logic [0:0] lp, input logic [63:0] e);
    @(posedge clk);
    ctl_rd <= 1'h1;
    ctl_rd_lp <= lp;
    @(posedge clk);
    ctl_rd <= 1'h0;
    @(negedge clk);
    chk("ctl_rd_data", e, ctl_rd_data);
  endtask
  // settle past one frame, then count stopped cycles over one whole frame;
  // compare in cycles so that a slot one cycle short is not rounded away
  task automatic meas(input logic [63:0] e);
    int n;
    n = 0;
    repeat (40) @(negedge clk);
    repeat (clock_mod_pkg::SLOTS_PER_FRAME * clock_mod_pkg::SLOT_CYCLES) begin
      @(negedge clk);
      if (core_stop_clk === 1'h1) n++;
    end
    chk("stop_cycles", e * 64'(clock_mod_pkg::SLOT_CYCLES), 64'(n));
    @(posedge clk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'h1;
    rd(1'h0, 64'h2);
    chk("feature_flags", 64'h2040_0000, 64'(feature_flags));
    $display("test reset done");
    wr(1'h0, 64'hFFFF_FFFF_FFFF_FFFF);
    rd(1'h0, 64'h1E);
    rd(1'h1, 64'h2);
    for (int c = 0; c < 8; c++) begin
      wr(1'h0, 64'h10 | (64'(c) << 1));
      meas(64'(c));
    end
    wr(1'h0, 64'hE);
    meas(64'h0);
    wr(1'h1, 64'h14);
    active_lp <= 1'h1;
    meas(64'h2);
    active_lp <= 1'h0;
    $display("test duty done");
    wr(1'h0, 64'h1E);
    wr(1'h1, 64'h1E);
    thermal_hot <= 1'h1;
    meas(64'h7);
    chk("thermal_status", 64'h1, 64'(thermal_status));
    misc(64'h8);
    meas(64'h4);
    thermal_hot <= 1'h0;
    meas(64'h7);
    chk("thermal_status", 64'h0, 64'(thermal_status));
    $display("test thermal done");
    // raise a request at the start of a stopped run so it must wait
    for (int i = 0; i < 40 && core_stop_clk !== 1'h0; i++) @(negedge clk);
    for (int i = 0; i < 40 && core_stop_clk !== 1'h1; i++) @(negedge clk);
    @(posedge clk);
    irq_req <= 1'h1;
    @(posedge clk);
    irq_req <= 1'h0;
    seen = 0;
    bad = 0;
    repeat (40) begin
      @(negedge clk);
      if (irq_deliver === 1'h1) seen = 1;
      if (irq_deliver === 1'h1 && core_stop_clk === 1'h1) bad++;
    end
    chk("irq_held", 64'h0, 64'(bad));
    chk("irq_delivered", 64'h1, 64'(seen));
    $display("test interrupt done");
    stop_test();
  end
endmodule
`default_nettype wire
